/* rtl/mid_core_decoder.sv */
// instruction decoder and sequencer: q phases, cycle counts, logical or execution
`timescale 1ns/1ps

// Overview of operation
// - base set plus extended stack instructions
// - single words, four double-word instructions
// - destination bit picks work or file
// - bit field picks bit in file
// - lone second word acts as nop
// - one cycle, two if taken or jump
// - double words two cycles, taken three
// - four q phases: decode read process write
// - or literal into work, n z
// - or file into chosen destination, n z
// - access bank or bank select register
module mid_core_decoder (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [mid_pkg::WORD_W-1:0] prog_word,
  input wire logic prog_valid,
  input wire logic cond_true,
  input wire logic [7:0] file_rdata,
  input wire logic [3:0] bank_select_register,
  output logic fetch_req,
  output logic [1:0] q_phase,
  output mid_pkg::mid_decode_t decoded,
  output logic [11:0] file_addr_out,
  output logic file_re,
  output mid_pkg::mid_exec_t exec_out,
  output logic [7:0] working_register,
  output logic flag_n,
  output logic flag_z,
  output logic nop_cycle
);
  import mid_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    mid_state_t s;
    logic [7:0] work;
    logic fn;
    logic fz;
    mid_exec_t ex;
    logic nop;
  } mid_all_t;

  mid_all_t r;
  mid_all_t next_r;
  mid_decode_t field_dec;

  mid_field_decode u_field (
    .word(prog_word),
    .second_word(r.s.second_pending),
    .dec(field_dec)
  );

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [11:0] mid_bank_addr(input logic a, input logic [7:0] f, input logic [3:0] bank);
    // access bank splits low ram and top special registers
    if (a) begin
      mid_bank_addr = {bank, f};
    end else if (f < ACCESS_SPLIT) begin
      mid_bank_addr = {ACCESS_BANK, f};
    end else begin
      mid_bank_addr = {ACCESS_HIGH_BANK, f};
    end
  endfunction : mid_bank_addr

  function automatic logic [1:0] mid_cycles(input mid_decode_t d, input logic taken);
    if (d.two_word) begin
      mid_cycles = (d.changes_pc && taken) ? 2'(CYC_DOUBLE_TAKEN) : 2'(CYC_DOUBLE);
    end else if (d.changes_pc || (d.conditional && taken)) begin
      mid_cycles = 2'(CYC_TAKEN);
    end else begin
      mid_cycles = 2'(CYC_SINGLE);
    end
  endfunction : mid_cycles

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r = r;
    next_r.ex.write_work = 1'b0;
    next_r.ex.write_file = 1'b0;
    next_r.ex.flag_we = 1'b0;
    next_r.s.q_phase = r.s.q_phase + 2'h1;
    unique case (r.s.q_phase)
      2'h0: begin
        // q1 decode: a new word is latched only at the start of a cycle
        if (!r.s.busy && prog_valid) begin
          next_r.s.ir = prog_word;
          next_r.s.dec = field_dec;
          next_r.s.busy = 1'b1;
          next_r.nop = (field_dec.kind == MID_K_NOP);
          next_r.s.second_pending = field_dec.two_word;
          next_r.s.cycles_left = mid_cycles(field_dec, cond_true) - 2'h1;
        end else if (r.s.busy) begin
          next_r.nop = 1'b1;
        end
      end
      2'h1: begin
        // q2 read operand
        next_r.s.operand = (r.s.dec.kind == MID_K_OR_LIT) ? r.s.dec.literal : file_rdata;
      end
      2'h2: begin
        // q3 process
        if (!r.nop) begin
          next_r.s.result = r.work | r.s.operand;
        end
      end
      2'h3: begin
        // q4 write back, then retire or burn a nop cycle
        if (r.s.busy && !r.nop) begin
          if (r.s.dec.kind == MID_K_OR_LIT) begin
            next_r.work = r.s.result;
            next_r.ex.write_work = 1'b1;
            next_r.ex.flag_we = 1'b1;
          end else if (r.s.dec.kind == MID_K_OR_FILE) begin
            next_r.ex.write_file = r.s.dec.dest_file;
            next_r.ex.write_work = !r.s.dec.dest_file;
            if (!r.s.dec.dest_file) begin
              next_r.work = r.s.result;
            end
            next_r.ex.flag_we = 1'b1;
          end
          if (r.s.dec.kind == MID_K_OR_LIT || r.s.dec.kind == MID_K_OR_FILE) begin
            next_r.fz = (r.s.result == RESET_BYTE);
            next_r.fn = r.s.result[7];
          end
          next_r.ex.result = r.s.result;
          next_r.ex.flag_z = (r.s.result == RESET_BYTE);
          next_r.ex.flag_n = r.s.result[7];
          next_r.ex.file_full_addr = mid_bank_addr(r.s.dec.bank_sel, r.s.dec.file_addr, bank_select_register);
        end
        if (r.s.busy) begin
          if (r.s.cycles_left == 2'h0) begin
            next_r.s.busy = 1'b0;
            next_r.s.second_pending = 1'b0;
          end else begin
            next_r.s.cycles_left = r.s.cycles_left - 2'h1;
            next_r.nop = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  // no word is fetched while an instruction is busy; the extra cycle of a double word runs only as a nop
  assign fetch_req = (r.s.q_phase == 2'h0) && !r.s.busy;
  assign q_phase = r.s.q_phase;
  assign decoded = r.s.dec;
  assign file_addr_out = mid_bank_addr(r.s.dec.bank_sel, r.s.dec.file_addr, bank_select_register);
  assign file_re = (r.s.q_phase == 2'h1) && r.s.busy && (r.s.dec.kind == MID_K_OR_FILE) && !r.nop;
  assign exec_out = r.ex;
  assign working_register = r.work;
  assign flag_n = r.fn;
  assign flag_z = r.fz;
  assign nop_cycle = r.nop;
endmodule : mid_core_decoder

/* rtl/mid_pkg.sv */
// package: opcode fields, encodings, cycle counts and carrier structs for the instruction decoder
package mid_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int Q_PER_CYCLE = 4;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam int CYC_SINGLE = 1;
  localparam int CYC_TAKEN = 2;
  localparam int CYC_DOUBLE = 2;
  localparam int CYC_DOUBLE_TAKEN = 3;
  localparam int STD_COUNT = 75;
  localparam int EXT_COUNT = 8;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
  localparam logic [7:0] OP_OR_LITERAL = 8'h09;
  localparam logic [5:0] OP_OR_FILE = 6'h04;
  localparam int POS_D = 9;
  localparam int POS_A = 8;
  localparam int POS_B_LO = 9;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_BANK = 4'h0;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  typedef enum logic [3:0] {
    MID_K_NOP, MID_K_OR_LIT, MID_K_OR_FILE, MID_K_BYTE, MID_K_BIT, MID_K_SKIP_BIT,
    MID_K_BRANCH, MID_K_GOTO2, MID_K_CALL2, MID_K_MOVFF2, MID_K_LFSR2, MID_K_LITERAL,
    MID_K_CONTROL, MID_K_EXTENDED
  } mid_kind_t;

  typedef struct packed {
    mid_kind_t kind;
    logic [7:0] file_addr;
    logic dest_file;
    logic bank_sel;
    logic [2:0] bit_num;
    logic [7:0] literal;
    logic two_word;
    logic changes_pc;
    logic conditional;
  } mid_decode_t;

  typedef struct packed {
    logic write_work;
    logic write_file;
    logic [11:0] file_full_addr;
    logic [7:0] result;
    logic flag_n;
    logic flag_z;
    logic flag_we;
  } mid_exec_t;

  typedef struct packed {
    logic [1:0] q_phase;
    logic [1:0] cycles_left;
    logic second_pending;
    logic [WORD_W-1:0] ir;
    mid_decode_t dec;
    logic [7:0] operand;
    logic [7:0] result;
    logic busy;
  } mid_state_t;
endpackage : mid_pkg

/* rtl/mid_field_decode.sv */
// combinational split of a program word into kind and operand fields
`timescale 1ns/1ps
module mid_field_decode (
  input wire logic [mid_pkg::WORD_W-1:0] word,
  input wire logic second_word,
  output mid_pkg::mid_decode_t dec
);
  import mid_pkg::*;

  always_comb begin
    dec = '0;
    dec.kind = MID_K_NOP;
    dec.file_addr = word[7:0];
    dec.dest_file = word[POS_D];
    dec.bank_sel = word[POS_A];
    dec.bit_num = word[POS_B_LO+2:POS_B_LO];
    dec.literal = word[7:0];
    if (second_word && word[15:12] == SECOND_WORD_TAG) begin
      dec.kind = MID_K_NOP;
    end else if (word[15:8] == OP_OR_LITERAL) begin
      dec.kind = MID_K_OR_LIT;
    end else if (word[15:10] == OP_OR_FILE) begin
      dec.kind = MID_K_OR_FILE;
    end else if (word[15:12] == SECOND_WORD_TAG) begin
      dec.kind = MID_K_NOP;
    end else if (word[15:12] == 4'hC) begin
      dec.kind = MID_K_MOVFF2;
      dec.two_word = 1'b1;
    end else if (word[15:8] == 8'hEF) begin
      dec.kind = MID_K_GOTO2;
      dec.two_word = 1'b1;
      dec.changes_pc = 1'b1;
    end else if (word[15:9] == 7'h76) begin
      dec.kind = MID_K_CALL2;
      dec.two_word = 1'b1;
      dec.changes_pc = 1'b1;
    end else if (word[15:6] == 10'h3B8) begin
      dec.kind = MID_K_LFSR2;
      dec.two_word = 1'b1;
    end else if (word[15:8] == 8'hE8 || word[15:8] == 8'hE9 || word[15:8] == 8'hEA || word[15:8] == 8'hEB) begin
      dec.kind = MID_K_EXTENDED;
    end else if (word[15:12] == 4'hE || word[15:12] == 4'hD) begin
      dec.kind = MID_K_BRANCH;
      dec.conditional = (word[15:12] == 4'hE);
      dec.changes_pc = (word[15:12] == 4'hD);
    end else if (word[15:13] == 3'h5 || word[15:12] == 4'h8 || word[15:12] == 4'h9) begin
      dec.kind = MID_K_BIT;
      dec.conditional = (word[15:12] == 4'hB) || (word[15:12] == 4'hA);
    end else if (word[15:12] == 4'h7) begin
      dec.kind = MID_K_BIT;
    end else if (word[15:12] == 4'h0) begin
      dec.kind = (word[11:8] == 4'h0) ? MID_K_CONTROL : MID_K_LITERAL;
    end else begin
      dec.kind = MID_K_BYTE;
    end
  end
endmodule : mid_field_decode

/* tb/mid_monitor.sv */
// checker for decoder sequencing, cycle counts and or results
`timescale 1ns/1ps
module mid_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] prog_word,
  input wire logic prog_valid,
  input wire logic cond_true,
  input wire logic [7:0] file_rdata,
  input wire logic [3:0] bank_select_register,
  input wire logic fetch_req,
  input wire logic [1:0] q_phase,
  input wire mid_pkg::mid_decode_t decoded,
  input wire logic [11:0] file_addr_out,
  input wire logic file_re,
  input wire mid_pkg::mid_exec_t exec_out,
  input wire logic [7:0] working_register,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic nop_cycle
);
  import mid_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  logic take, or_lit, or_file, d_bit, a_bit;
  logic [7:0] low;
  assign take = fetch_req && prog_valid;
  assign or_lit = take && prog_word[15:8] == OP_OR_LITERAL;
  assign or_file = take && prog_word[15:10] == OP_OR_FILE;
  assign d_bit = prog_word[POS_D];
  assign a_bit = prog_word[POS_A];
  assign low = prog_word[7:0];
  sequence s_quad;
    q_phase == 2'h1 ##1 q_phase == 2'h2 ##1 q_phase == Q_LAST ##1 q_phase == 2'h0;
  endsequence
  sequence s_skip;
    take && cond_true ##1 decoded.conditional && !decoded.two_word;
  endsequence
  ////////////////////////////////////////////////////////////
  AST_QUAD: assert property (
    q_phase == 2'h1 |-> s_quad) else $error("q phase order broken");
  AST_FETCH: assert property (
    fetch_req |-> q_phase == 2'h0 ##1 q_phase == 2'h1) else $error("fetch outside phase zero");
  AST_OR_LIT: assert property (
    or_lit |-> ##4 exec_out.write_work && !exec_out.write_file
    && working_register == ($past(working_register, 4) | $past(low, 4))) else $error("or literal wrong");
  AST_FLAGS: assert property (
    or_lit || or_file |-> ##4 exec_out.flag_we && flag_z == (exec_out.result == 8'h00)
    && flag_n == exec_out.result[7]) else $error("or flags wrong");
  AST_OR_FILE: assert property (
    or_file |-> ##1 file_re ##3 exec_out.result == ($past(working_register, 4) | $past(file_rdata, 3))
    && exec_out.write_file == $past(d_bit, 4) && exec_out.write_work == !$past(d_bit, 4)) else $error("or file wrong");
  AST_BANK: assert property (
    file_re |-> file_addr_out == {$past(a_bit) ? bank_select_register
    : ($past(low) < ACCESS_SPLIT ? ACCESS_BANK : ACCESS_HIGH_BANK), $past(low)}) else $error("bank address wrong");
  AST_LONE: assert property (
    take && prog_word[15:12] == SECOND_WORD_TAG |-> ##4 !exec_out.write_work && !exec_out.write_file
    && working_register == $past(working_register, 4)) else $error("lone second word not a nop");
  AST_ONE_CYCLE: assert property (
    or_lit |=> !fetch_req [*3] ##1 fetch_req) else $error("or literal not one cycle");
  AST_SKIP: assert property (
    s_skip |-> ##3 !fetch_req ##1 nop_cycle ##3 fetch_req) else $error("taken skip not two cycles");
  AST_TWO: assert property (
    take && !cond_true ##1 decoded.two_word |-> ##3 !fetch_req ##4 fetch_req) else $error("double word not two");
  AST_TWO_TAKEN: assert property (
    take && cond_true ##1 decoded.two_word && decoded.changes_pc |-> ##3 !fetch_req ##4 !fetch_req ##4 fetch_req)
    else $error("taken double word not three");
endmodule : mid_monitor

bind mid_core_decoder mid_monitor mon (.clk_sys, .rst_n, .prog_word, .prog_valid, .cond_true, .file_rdata,
  .bank_select_register, .fetch_req, .q_phase, .decoded, .file_addr_out, .file_re, .exec_out,
  .working_register, .flag_n, .flag_z, .nop_cycle);

/* tb/mid_prog_mem.sv */
// program memory model handing words to the decoder
`timescale 1ns/1ps
module mid_prog_mem (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fetch_req,
  input wire logic file_re,
  input wire logic stall,
  input wire logic [7:0] fdata,
  output logic [15:0] prog_word,
  output logic prog_valid,
  output logic [7:0] file_rdata
);
  logic [15:0] mem [16];
  logic [3:0] pc;
  // inverted data when idle so a stale word never passes for a real one
  assign prog_valid = !stall;
  assign prog_word = stall ? ~mem[pc] : mem[pc];
  assign file_rdata = file_re ? fdata : ~fdata;
  // second words of double-word instructions are never stored, the source skips them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pc <= 4'h0;
    end else if (fetch_req && !stall) begin
      pc <= pc + 4'h1;
    end
  end
endmodule : mid_prog_mem

/* tb/mid_core_decoder_tb.sv */
// testbench for the instruction decoder
`timescale 1ns/1ps
module mid_core_decoder_tb;
  import mid_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cond_true = 1'b0;
  logic stall = 1'b1;
  logic [7:0] fdata = 8'h00;
  logic [3:0] bank_select_register = 4'h5;
  logic [15:0] prog_word;
  logic prog_valid, fetch_req, file_re, flag_n, flag_z, nop_cycle, nop6;
  logic [1:0] q_phase;
  logic [7:0] file_rdata, working_register;
  logic [11:0] file_addr_out, addr1;
  mid_decode_t decoded;
  mid_exec_t exec_out;
  int mismatches = 0;
  int samples_checked = 0;
  always #25 clk_sys = ~clk_sys;
  mid_prog_mem pm (.clk_sys, .rst_n, .fetch_req, .file_re, .stall, .fdata, .prog_word, .prog_valid, .file_rdata);
  mid_core_decoder dut (.clk_sys, .rst_n, .prog_word, .prog_valid, .cond_true, .file_rdata, .bank_select_register,
    .fetch_req, .q_phase, .decoded, .file_addr_out, .file_re, .exec_out, .working_register, .flag_n, .flag_z,
    .nop_cycle);
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // offers one word, then counts clocks until the next fetch slot
  task automatic run(input logic [15:0] w, input logic c, output int n);
    int k = 0;
    @(posedge clk_sys);
    pm.mem[pm.pc] <= w;
    stall <= 1'b0;
    cond_true <= c;
    do begin
      @(negedge clk_sys);
      k++;
    end while (!fetch_req && k < 20);
    @(posedge clk_sys);
    stall <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (n == 1) addr1 = file_addr_out;
      if (n == 6) nop6 = nop_cycle;
    end while (!fetch_req && n < 20);
    if (k >= 20 || n >= 20) begin
      mismatches++;
      end_sim();
    end
  endtask : run
  ////////////////////////////////////////////////////////////
  task automatic t_or_file(input logic d, input logic a, input logic [7:0] f, input logic [7:0] v,
                           input logic [7:0] r, input logic [11:0] ad);
    int n;
    @(posedge clk_sys);
    fdata <= v;
    run({OP_OR_FILE, d, a, f}, 1'b0, n);
    chk(addr1, ad);
    chk(exec_out.file_full_addr, ad);
    chk(exec_out.result, r);
    chk({exec_out.write_file, exec_out.write_work}, {d, !d});
    chk({flag_n, flag_z}, {r[7], r == 8'h00});
  endtask : t_or_file
  task automatic t_or_lit(input logic [7:0] k, input logic [7:0] r);
    int n;
    run({OP_OR_LITERAL, k}, 1'b0, n);
    chk(16'(n), 16'h4);
    chk(working_register, r);
    chk({flag_n, flag_z}, {r[7], r == 8'h00});
  endtask : t_or_lit
  task automatic t_timing(input logic [15:0] w, input logic c, input int cyc);
    int n;
    run(w, c, n);
    chk(16'(n), 16'(cyc));
    chk(decoded.two_word, w[15:12] == 4'hC || w[15:8] == 8'hEF);
    if (w[15:10] == 6'h3A) chk(16'(decoded.kind), 16'(MID_K_EXTENDED));
    if (cyc > 4) chk(nop6, 1'b1);
    if (w[15:12] == 4'hB) chk(decoded.bit_num, w[11:9]);
    if (w[15:12] == SECOND_WORD_TAG) chk({exec_out.write_work, exec_out.write_file}, 2'h0);
  endtask : t_timing
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_or_file(1'b1, 1'b0, 8'h10, 8'h80, 8'h80, 12'h010);
    t_or_file(1'b0, 1'b1, 8'h70, 8'h00, 8'h00, 12'h570);
    t_or_file(1'b0, 1'b0, 8'h70, 8'h21, 8'h21, 12'hF70);
    t_or_lit(8'h00, 8'h21);
    t_or_lit(8'h9A, 8'hBB);
    t_timing(16'hF123, 1'b0, 4);
    t_timing(16'hB712, 1'b0, 4);
    t_timing(16'hB712, 1'b1, 8);
    t_timing(16'hD005, 1'b0, 8);
    t_timing(16'hEF12, 1'b0, 8);
    t_timing(16'hEF12, 1'b1, 12);
    t_timing(16'hC123, 1'b0, 8);
    t_timing(16'hE812, 1'b0, 4);
    end_sim();
  end
endmodule : mid_core_decoder_tb
